// file: rtl/rxpeq_defines.svh
/*
 * Offsets, field positions, reset values and timing figures of the receive
 * port paging and adaptive equalizer block.
 * Assumes it is included by bare name from the block's package and modules.
 */
`ifndef RXPEQ_DEFINES_SVH
`define RXPEQ_DEFINES_SVH

// Shared register offsets.
`define RXPEQ_OFS_RX_EN        8'h0c
`define RXPEQ_OFS_PAGE_SEL     8'h4c
`define RXPEQ_OFS_PORT0_ADDR   8'hf8
`define RXPEQ_OFS_PORT3_ADDR   8'hfb
// Per-port (paged) register offsets.
`define RXPEQ_OFS_ERR_SEL      8'h42
`define RXPEQ_OFS_ROBUST       8'hb9
`define RXPEQ_OFS_EQ_CTL       8'hd2
`define RXPEQ_OFS_EQ_STATUS    8'hd3
`define RXPEQ_OFS_EQ_THRESH    8'hd4
`define RXPEQ_OFS_EQ_MINMAX    8'hd5

// Field positions.
`define RXPEQ_CTL_RESTART      0
`define RXPEQ_CTL_FIRST_RST    1
`define RXPEQ_CTL_FLOOR_EN     2
`define RXPEQ_CTL_DWELL_LSB    5
`define RXPEQ_CTL_DWELL_MSB    7
`define RXPEQ_ROB_TALLY_EN     0
`define RXPEQ_ROB_FILT_WAIT    1
`define RXPEQ_STAT_LOCK        7
`define RXPEQ_MM_FLOOR_LSB     0
`define RXPEQ_MM_MAX_LSB       4
`define RXPEQ_PAGE_MSB         1
`define RXPEQ_ERR_SEL_MSB      2

// Reset values.
`define RXPEQ_RST_RX_EN        8'h0f
`define RXPEQ_RST_ERR_SEL      8'h07
`define RXPEQ_RST_ROBUST       8'h00
`define RXPEQ_RST_EQ_CTL       8'h02
`define RXPEQ_RST_EQ_THRESH    8'h04
`define RXPEQ_RST_EQ_MINMAX    8'hf0
`define RXPEQ_RST_PORT_ADDR    8'h00

// Equalizer dwell interval in ns, and the clock period in ns.
`define RXPEQ_DWELL_NS         2620000
`define RXPEQ_CLK_NS           20

`endif

// file: rtl/rxpeq_pkg.sv
/*
 * Types of the receive port paging and adaptive equalizer block.
 * Assumes rxpeq_defines.svh is on the include path.
 */
`include "rxpeq_defines.svh"

package rxpeq_pkg;

   typedef enum logic [2:0] {
      EQS_IDLE  = 3'b001,
      EQS_DWELL = 3'b010,
      EQS_HOLD  = 3'b100
   } rxpeq_state_e;

   // One register access from the I2C target front end.
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       remote;
      logic [1:0] link_port;
      logic [6:0] i2c_addr;
      logic [7:0] offset;
      logic [7:0] wdata;
   } rxpeq_req_s;

   // Equalizer search limits of one port.
   typedef struct packed {
      logic       floor_en;
      logic [3:0] floor_val;
      logic [3:0] max_val;
      logic [7:0] thresh;
      logic       first_restart_en;
      logic       filt_wait;
   } rxpeq_eqcfg_s;

endpackage : rxpeq_pkg

// file: rtl/rxpeq_eq_search.sv
/*
 * Adaptive equalizer search engine for one receive port.
 * Assumes lock and error inputs are synchronous to the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rxpeq_defines.svh"

module rxpeq_eq_search
   import rxpeq_pkg::*;
#(
   parameter int EQ_W  = 4,
   parameter int CNT_W = 18
) (
   // Clock, reset, enable.
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             ce_i,
   // Control.
   input  wire logic             en_i,
   input  wire logic             restart_i,
   input  wire rxpeq_eqcfg_s     cfg_i,
   input  wire logic [CNT_W-1:0] dwell_i,
   // Link status.
   input  wire logic             lock_i,
   input  wire logic             err_i,
   // Result.
   output logic      [EQ_W-1:0]  eq_o,
   output logic                  locked_o
);

   rxpeq_state_e     st_reg, st_next;
   logic [EQ_W-1:0]  eq_reg, eq_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [7:0]       err_reg, err_next;
   logic             half_lock_reg, half_lock_next;
   logic             first_reg, first_next;
   logic             en_d_reg, en_d_next;
   logic [EQ_W-1:0]  start_val, adv_val;
   logic [CNT_W-1:0] half;

   assign start_val = cfg_i.floor_en ? cfg_i.floor_val : '0;
   assign adv_val   = (eq_reg >= cfg_i.max_val) ? start_val : eq_reg + 1'b1;
   assign half      = dwell_i >> 1;

   always_comb begin
      st_next        = st_reg;
      eq_next        = eq_reg;
      cnt_next       = cnt_reg;
      err_next       = err_reg;
      half_lock_next = half_lock_reg;
      first_next     = first_reg;
      en_d_next      = en_i;
      if (!en_i) begin
         // A disabled port neither searches nor watches lock.
         st_next    = EQS_IDLE;
         eq_next    = start_val;
         cnt_next   = '0;
         err_next   = '0;
         first_next = 1'b0;
      end else if (restart_i || !en_d_reg || st_reg == EQS_IDLE) begin
         st_next  = EQS_DWELL;
         eq_next  = start_val;
         cnt_next = '0;
         err_next = '0;
      end else begin
         unique case (st_reg)
            EQS_DWELL: begin
               cnt_next = cnt_reg + 1'b1;
               if (err_i && cnt_reg < half && err_reg != 8'hff) begin
                  err_next = err_reg + 1'b1;
               end
               if (half != '0 && cnt_reg == half - 1'b1) begin
                  half_lock_next = lock_i;
                  if (err_reg > cfg_i.thresh) begin
                     eq_next  = adv_val;
                     cnt_next = '0;
                     err_next = '0;
                  end
               end
               if (cnt_reg >= dwell_i - 1'b1) begin
                  cnt_next = '0;
                  err_next = '0;
                  if (lock_i && (!cfg_i.filt_wait || half_lock_reg)) begin
                     if (cfg_i.first_restart_en && !first_reg) begin
                        // One fresh pass from known conditions after first lock.
                        first_next = 1'b1;
                        eq_next    = start_val;
                     end else begin
                        st_next = EQS_HOLD;
                     end
                  end else begin
                     eq_next = adv_val;
                  end
               end
            end
            EQS_HOLD: begin
               if (!lock_i) begin
                  st_next  = EQS_DWELL;
                  eq_next  = adv_val;
                  cnt_next = '0;
                  err_next = '0;
               end
            end
            default: st_next = EQS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg        <= EQS_IDLE;
         eq_reg        <= '0;
         cnt_reg       <= '0;
         err_reg       <= '0;
         half_lock_reg <= 1'b0;
         first_reg     <= 1'b0;
         en_d_reg      <= 1'b0;
      end else if (ce_i) begin
         st_reg        <= st_next;
         eq_reg        <= eq_next;
         cnt_reg       <= cnt_next;
         err_reg       <= err_next;
         half_lock_reg <= half_lock_next;
         first_reg     <= first_next;
         en_d_reg      <= en_d_next;
      end
   end

   assign eq_o     = eq_reg;
   assign locked_o = (st_reg == EQS_HOLD);

   a_hold_steady: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && st_reg == EQS_HOLD && lock_i && en_i && !restart_i) |=> $stable(eq_reg) && st_reg == EQS_HOLD)
      else $error("equalizer setting moved while lock held");
   a_lost_advance: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && st_reg == EQS_HOLD && !lock_i && en_i && en_d_reg && !restart_i)
      |=> st_reg == EQS_DWELL && eq_reg == $past(adv_val))
      else $error("lock loss did not advance the equalizer");
   a_idle_disabled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && !en_i) |=> st_reg == EQS_IDLE && cnt_reg == '0)
      else $error("disabled port not idle");
   a_restart_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && en_i && restart_i) |=> st_reg == EQS_DWELL && eq_reg == $past(start_val) && cnt_reg == '0)
      else $error("restart did not reload the start setting");
   a_dwell_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && $past(ce_i) && $stable(dwell_i) && st_reg == EQS_DWELL && dwell_i != '0) |-> cnt_reg < dwell_i)
      else $error("dwell counter ran past the interval");

endmodule : rxpeq_eq_search
`default_nettype wire

// file: rtl/rxpeq_top.sv
/*
 * Receive port enable, per-port register paging and direct port addressing,
 * and four adaptive equalizer search engines.
 * Assumes an I2C target front end delivers one decoded access per REQ_I.valid
 * cycle, and that lock and error inputs are synchronous to SYS_CLK_I.
 *
// How it works
// - Four inputs, each disableable by enable bit.
// - Enable bits writable only by local host.
// - Page select picks per-port register set.
// - Page select defaults to the accessing port.
// - Four 7-bit direct addresses reach port registers.
// - Direct addresses also reach shared registers.
// - Equalizer control and status at four registers.
// - Lock loss reruns the equalizer lock search.
// - Step settings, wait dwell, then check lock.
// - Valid lock freezes the setting while held.
// - Lost lock resumes search at next setting.
// - Restart bit restarts the search any time.
// - Past maximum, wrap to minimum or floor.
// - Errors over half dwell above threshold advance.
// - Restart once after first lock indication.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rxpeq_defines.svh"

module rxpeq_top
   import rxpeq_pkg::*;
#(
   parameter logic [6:0] DEV_I2C_ADDR = 7'h3d,
   parameter int         NPORT        = 4,
   parameter int         EQ_W         = 4,
   parameter int         CNT_W        = 18,
   parameter int         DWELL_CYCLES = `RXPEQ_DWELL_NS / `RXPEQ_CLK_NS
) (
   // Clock, reset, enable.
   input  wire logic                      SYS_CLK_I,
   input  wire logic                      RESETN_I,
   input  wire logic                      CE_I,
   // Register access from the I2C target.
   input  wire rxpeq_req_s                REQ_I,
   output logic                           ACK_O,
   output logic      [7:0]                RDATA_O,
   // Receive port status.
   input  wire logic [NPORT-1:0]          CDR_LOCK_I,
   input  wire logic [NPORT-1:0][2:0]     LINK_ERR_I,
   // Receive port controls.
   output logic      [NPORT-1:0]          RX_ENABLE_O,
   output logic      [NPORT-1:0][EQ_W-1:0] EQ_SETTING_O,
   output logic      [NPORT-1:0]          EQ_LOCKED_O
);

   localparam logic [CNT_W-1:0] DWELL_BASE = CNT_W'(DWELL_CYCLES);

   logic [7:0]       rx_en_reg, rx_en_next;
   logic [7:0]       page_reg [NPORT+1], page_next [NPORT+1];
   logic [7:0]       addr_reg [NPORT], addr_next [NPORT];
   logic [7:0]       errsel_reg [NPORT], errsel_next [NPORT];
   logic [7:0]       robust_reg [NPORT], robust_next [NPORT];
   logic [7:0]       ctl_reg [NPORT], ctl_next [NPORT];
   logic [7:0]       thr_reg [NPORT], thr_next [NPORT];
   logic [7:0]       mm_reg [NPORT], mm_next [NPORT];
   logic             ack_reg, ack_next;
   logic [7:0]       rdata_reg, rdata_next;
   logic [NPORT-1:0] restart_pulse;
   logic [NPORT-1:0] direct_match;
   logic             direct_hit, main_hit, hit, wr;
   logic [1:0]       direct_port, tgt, src;
   logic [EQ_W-1:0]  eq_val [NPORT];
   logic [NPORT-1:0] eq_lock;

   // Remote hosts each own a page pointer, so one link cannot repage another.
   assign src = REQ_I.link_port;

   always_comb begin
      direct_hit  = 1'b0;
      direct_port = 2'd0;
      for (int p = 0; p < NPORT; p++) begin
         if (direct_match[p] && !direct_hit) begin
            direct_hit  = 1'b1;
            direct_port = 2'(p);
         end
      end
   end

   assign main_hit = (REQ_I.i2c_addr == DEV_I2C_ADDR);
   assign hit      = REQ_I.valid && (main_hit || direct_hit);
   assign wr       = hit && REQ_I.write;
   assign tgt      = direct_hit ? direct_port
                   : REQ_I.remote ? page_reg[src + 1][`RXPEQ_PAGE_MSB:0]
                   : page_reg[0][`RXPEQ_PAGE_MSB:0];

   always_comb begin
      rx_en_next  = rx_en_reg;
      page_next   = page_reg;
      addr_next   = addr_reg;
      errsel_next = errsel_reg;
      robust_next = robust_reg;
      ctl_next    = ctl_reg;
      thr_next    = thr_reg;
      mm_next     = mm_reg;
      ack_next    = hit;
      rdata_next  = rdata_reg;
      restart_pulse = '0;
      if (wr) begin
         unique case (REQ_I.offset)
            `RXPEQ_OFS_RX_EN: begin
               if (!REQ_I.remote) begin
                  rx_en_next = REQ_I.wdata;
               end
            end
            `RXPEQ_OFS_PAGE_SEL: begin
               if (REQ_I.remote) begin
                  page_next[src + 1] = REQ_I.wdata;
               end else begin
                  page_next[0] = REQ_I.wdata;
               end
            end
            `RXPEQ_OFS_ERR_SEL: errsel_next[tgt] = REQ_I.wdata;
            `RXPEQ_OFS_ROBUST:  robust_next[tgt] = REQ_I.wdata;
            `RXPEQ_OFS_EQ_CTL: begin
               ctl_next[tgt] = REQ_I.wdata & ~(8'h01 << `RXPEQ_CTL_RESTART);
               restart_pulse[tgt] = REQ_I.wdata[`RXPEQ_CTL_RESTART];
            end
            `RXPEQ_OFS_EQ_THRESH: thr_next[tgt] = REQ_I.wdata;
            `RXPEQ_OFS_EQ_MINMAX: mm_next[tgt]  = REQ_I.wdata;
            default: begin
               if (REQ_I.offset >= `RXPEQ_OFS_PORT0_ADDR && REQ_I.offset <= `RXPEQ_OFS_PORT3_ADDR) begin
                  addr_next[2'(REQ_I.offset - `RXPEQ_OFS_PORT0_ADDR)] = REQ_I.wdata;
               end
            end
         endcase
      end else if (hit) begin
         unique case (REQ_I.offset)
            `RXPEQ_OFS_RX_EN:     rdata_next = rx_en_reg;
            `RXPEQ_OFS_PAGE_SEL:  rdata_next = REQ_I.remote ? page_reg[src + 1] : page_reg[0];
            `RXPEQ_OFS_ERR_SEL:   rdata_next = errsel_reg[tgt];
            `RXPEQ_OFS_ROBUST:    rdata_next = robust_reg[tgt];
            `RXPEQ_OFS_EQ_CTL:    rdata_next = ctl_reg[tgt];
            `RXPEQ_OFS_EQ_STATUS: begin
               rdata_next = 8'(eq_val[tgt]);
               rdata_next[`RXPEQ_STAT_LOCK] = eq_lock[tgt];
            end
            `RXPEQ_OFS_EQ_THRESH: rdata_next = thr_reg[tgt];
            `RXPEQ_OFS_EQ_MINMAX: rdata_next = mm_reg[tgt];
            default: begin
               if (REQ_I.offset >= `RXPEQ_OFS_PORT0_ADDR && REQ_I.offset <= `RXPEQ_OFS_PORT3_ADDR) begin
                  rdata_next = addr_reg[2'(REQ_I.offset - `RXPEQ_OFS_PORT0_ADDR)];
               end else begin
                  rdata_next = 8'h00;
               end
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rx_en_reg <= `RXPEQ_RST_RX_EN;
         ack_reg   <= 1'b0;
         rdata_reg <= 8'h00;
         page_reg[0] <= 8'h00;
         for (int p = 0; p < NPORT; p++) begin
            page_reg[p + 1] <= 8'(p);
            addr_reg[p]     <= `RXPEQ_RST_PORT_ADDR;
            errsel_reg[p]   <= `RXPEQ_RST_ERR_SEL;
            robust_reg[p]   <= `RXPEQ_RST_ROBUST;
            ctl_reg[p]      <= `RXPEQ_RST_EQ_CTL;
            thr_reg[p]      <= `RXPEQ_RST_EQ_THRESH;
            mm_reg[p]       <= `RXPEQ_RST_EQ_MINMAX;
         end
      end else if (CE_I) begin
         rx_en_reg  <= rx_en_next;
         ack_reg    <= ack_next;
         rdata_reg  <= rdata_next;
         page_reg   <= page_next;
         addr_reg   <= addr_next;
         errsel_reg <= errsel_next;
         robust_reg <= robust_next;
         ctl_reg    <= ctl_next;
         thr_reg    <= thr_next;
         mm_reg     <= mm_next;
      end
   end

   generate
      for (genvar g = 0; g < NPORT; g++) begin : g_port
         rxpeq_eqcfg_s     cfg;
         logic [CNT_W-1:0] dwell;
         logic             err_any;

         // A zero address disables the direct alias of the port.
         assign direct_match[g] = (addr_reg[g] != 8'h00) && (addr_reg[g][7:1] == REQ_I.i2c_addr);
         assign dwell = DWELL_BASE >> ctl_reg[g][`RXPEQ_CTL_DWELL_MSB:`RXPEQ_CTL_DWELL_LSB];
         assign err_any = robust_reg[g][`RXPEQ_ROB_TALLY_EN]
                        && |(LINK_ERR_I[g] & errsel_reg[g][`RXPEQ_ERR_SEL_MSB:0]);
         assign cfg.floor_en         = ctl_reg[g][`RXPEQ_CTL_FLOOR_EN];
         assign cfg.floor_val        = mm_reg[g][`RXPEQ_MM_FLOOR_LSB +: 4];
         assign cfg.max_val          = mm_reg[g][`RXPEQ_MM_MAX_LSB +: 4];
         assign cfg.thresh           = thr_reg[g];
         assign cfg.first_restart_en = ctl_reg[g][`RXPEQ_CTL_FIRST_RST];
         assign cfg.filt_wait        = robust_reg[g][`RXPEQ_ROB_FILT_WAIT];

         rxpeq_eq_search #(
            .EQ_W  (EQ_W),
            .CNT_W (CNT_W)
         ) u_eq (
            .clk_i     (SYS_CLK_I),
            .rst_n_i   (RESETN_I),
            .ce_i      (CE_I),
            .en_i      (rx_en_reg[g]),
            .restart_i (restart_pulse[g]),
            .cfg_i     (cfg),
            .dwell_i   ((dwell == '0) ? CNT_W'(1) : dwell),
            .lock_i    (CDR_LOCK_I[g]),
            .err_i     (err_any),
            .eq_o      (eq_val[g]),
            .locked_o  (eq_lock[g])
         );

         assign RX_ENABLE_O[g]  = rx_en_reg[g];
         assign EQ_SETTING_O[g] = eq_val[g];
         assign EQ_LOCKED_O[g]  = eq_lock[g];
      end
   endgenerate

   assign ACK_O   = ack_reg;
   assign RDATA_O = rdata_reg;

   a_remote_enable: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (CE_I && wr && REQ_I.remote && REQ_I.offset == `RXPEQ_OFS_RX_EN) |=> $stable(rx_en_reg))
      else $error("remote write changed the port enables");
   a_local_enable: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (CE_I && wr && !REQ_I.remote && REQ_I.offset == `RXPEQ_OFS_RX_EN)
      |=> RX_ENABLE_O == $past(REQ_I.wdata[NPORT-1:0]))
      else $error("local write did not set the port enables");
   a_ack_timing: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (CE_I && REQ_I.valid && direct_hit) |=> ACK_O)
      else $error("direct address access not acknowledged");
   a_direct_route: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (CE_I && wr && direct_hit && REQ_I.offset == `RXPEQ_OFS_EQ_THRESH)
      |=> thr_reg[$past(direct_port)] == $past(REQ_I.wdata))
      else $error("direct write missed the port register");

endmodule : rxpeq_top
`default_nettype wire

// file: verif/rxpeq_link_model.sv
/*
 * Far-side link model: one clock recovery lock per receive port.
 * Assumes the bench chooses the one equalizer setting that each cable accepts.
 */
`timescale 1ns/1ns
`default_nettype none

module rxpeq_link_model (
   // Clock and reset.
   input  wire logic            clk_i,
   input  wire logic            rst_n_i,
   // Receiver state and cable choice.
   input  wire logic [3:0]      rx_en_i,
   input  wire logic [3:0][3:0] eq_i,
   input  wire logic [3:0][3:0] good_i,
   // Lock seen by the receiver.
   output logic      [3:0]      lock_o
);
   // Lock lags the setting by a cycle, so on the edge the engine steps it still sees the lock of the old setting.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock_o <= 4'h0;
      end else begin
         for (int p = 0; p < 4; p++) begin
            lock_o[p] <= rx_en_i[p] && (eq_i[p] == good_i[p]);
         end
      end
   end
endmodule : rxpeq_link_model

`default_nettype wire

// file: verif/rxpeq_top_test.sv
/*
 * Self-checking bench of the port paging and equalizer block.
 * Assumes the link model stands in for the cables and the bench for the host.
 */
`timescale 1ns/1ns
`default_nettype none

module rxpeq_top_test;
   import rxpeq_pkg::*;
   localparam int         DW = 16;
   localparam logic [6:0] MA = 7'h3d;
   logic            clk, rst_n, ack, ak, ce;
   rxpeq_req_s      req;
   logic [7:0]      rdata, rd;
   logic [3:0]      lock, rx_en, eq_lk;
   logic [3:0][2:0] err;
   logic [3:0][3:0] eq, good;
   int              miscompares, num_checks;

   rxpeq_top #(.DEV_I2C_ADDR(MA), .DWELL_CYCLES(DW)) uut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce),
      .REQ_I(req), .ACK_O(ack), .RDATA_O(rdata), .CDR_LOCK_I(lock), .LINK_ERR_I(err),
      .RX_ENABLE_O(rx_en), .EQ_SETTING_O(eq), .EQ_LOCKED_O(eq_lk));
   rxpeq_link_model link (.clk_i(clk), .rst_n_i(rst_n), .rx_en_i(rx_en), .eq_i(eq), .good_i(good),
      .lock_o(lock));

   task automatic test_done();
      if (miscompares == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk

   task automatic acc(input bit rem, input logic [1:0] lp, input logic [6:0] a, input logic [7:0] o,
                      input bit wr, input logic [7:0] wd);
      @(posedge clk);
      #1 req = '{1'b1, wr, rem, lp, a, o, wd};
      @(posedge clk);
      #1 req.valid = 1'b0;
      ak = ack;
      rd = rdata;
   endtask : acc

   task automatic rchk(input logic [6:0] a, input logic [7:0] o, input logic [7:0] e, input string m);
      acc(1'b0, 2'h0, a, o, 1'b0, 8'h00);
      chk(ak === 1'b1 && rd === e, m);
   endtask : rchk

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic wait_lock(input int p, input logic v, input int n, output int c);
      c = 0;
      while (eq_lk[p] !== v) begin
         step(1);
         c++;
         if (c > n) begin
            chk(1'b0, "lock state wait ran out");
            test_done();
         end
      end
   endtask : wait_lock

   task automatic t_reset();
      chk(rx_en === 4'hf, "enables after reset");
      rchk(MA, 8'h0c, 8'h0f, "enable reg reset");
      rchk(MA, 8'h4c, 8'h00, "local page reset");
      rchk(MA, 8'h42, 8'h07, "error select reset");
      rchk(MA, 8'hb9, 8'h00, "robustness reset");
      rchk(MA, 8'hd2, 8'h02, "eq control reset");
      rchk(MA, 8'hd4, 8'h04, "threshold reset");
      rchk(MA, 8'hd5, 8'hf0, "eq range reset");
      rchk(MA, 8'hfb, 8'h00, "direct address reset");
      rchk(MA, 8'h77, 8'h00, "unknown offset read");
      acc(1'b0, 2'h0, 7'h11, 8'h0c, 1'b0, 8'h00);
      chk(ak === 1'b0, "unmapped address answered");
   endtask : t_reset

   task automatic t_enable();
      acc(1'b1, 2'h2, MA, 8'h0c, 1'b1, 8'h00);
      step(2);
      chk(rx_en === 4'hf && ak === 1'b1, "remote write took effect");
      acc(1'b0, 2'h0, MA, 8'h0c, 1'b1, 8'h0e);
      step(2);
      chk(rx_en === 4'he && eq[0] === 4'h0, "port 0 not disabled");
      step(3 * DW);
      chk(eq[0] === 4'h0 && eq_lk[0] === 1'b0, "disabled port searched");
      acc(1'b0, 2'h0, MA, 8'h0c, 1'b1, 8'h0f);
   endtask : t_enable

   task automatic t_paging();
      acc(1'b1, 2'h2, MA, 8'h4c, 1'b0, 8'h00);
      chk(ak === 1'b1 && rd === 8'h02, "remote page default");
      acc(1'b0, 2'h0, MA, 8'h4c, 1'b1, 8'h01);
      acc(1'b0, 2'h0, MA, 8'hd4, 1'b1, 8'h33);
      rchk(MA, 8'hd4, 8'h33, "page 1 threshold");
      acc(1'b0, 2'h0, MA, 8'h4c, 1'b1, 8'h00);
      rchk(MA, 8'hd4, 8'h04, "page 0 threshold");
      acc(1'b0, 2'h0, MA, 8'hf9, 1'b1, 8'h42);
      rchk(7'h21, 8'hd4, 8'h33, "direct port 1 reg");
      rchk(7'h21, 8'h0c, 8'h0f, "shared reg via direct");
   endtask : t_paging

   task automatic t_search();
      int c;
      good[0] = 4'h3;
      acc(1'b0, 2'h0, MA, 8'hd2, 1'b1, 8'h01);
      chk(eq[0] === 4'h0 && eq_lk[0] === 1'b0, "restart not at start");
      wait_lock(0, 1'b1, 4 * DW + 8, c);
      chk(eq[0] === 4'h3 && c >= 3 * DW, "lock setting or dwell");
      step(2 * DW);
      chk(eq[0] === 4'h3 && eq_lk[0] === 1'b1, "setting moved in lock");
      rchk(MA, 8'hd3, 8'h83, "status readback");
      good[0] = 4'h5;
      wait_lock(0, 1'b0, 4, c);
      step(1);
      chk(eq[0] === 4'h4, "no step after lock loss");
      wait_lock(0, 1'b1, 2 * DW + 8, c);
      chk(eq[0] === 4'h5, "relock setting");
      acc(1'b0, 2'h0, MA, 8'hd2, 1'b1, 8'h01);
      step(1);
      chk(eq[0] === 4'h0 && eq_lk[0] === 1'b0, "restart in lock");
   endtask : t_search

   task automatic t_wrap();
      logic [3:0] prev;
      bit         seen;
      bit         bad;
      good[0] = 4'hf;
      acc(1'b0, 2'h0, MA, 8'hd5, 1'b1, 8'h52);
      // The floor enable must stand before the restart that is to use it.
      acc(1'b0, 2'h0, MA, 8'hd2, 1'b1, 8'h04);
      acc(1'b0, 2'h0, MA, 8'hd2, 1'b1, 8'h05);
      step(1);
      chk(eq[0] === 4'h2, "floor start");
      {seen, bad, prev} = {2'b00, eq[0]};
      repeat (6 * DW) begin
         step(1);
         seen |= (prev === 4'h5 && eq[0] === 4'h2);
         bad |= ((eq[0] inside {[4'h2:4'h5]}) !== 1'b1);
         prev = eq[0];
      end
      chk(seen && !bad, "wrap to floor");
      acc(1'b0, 2'h0, MA, 8'hd5, 1'b1, 8'hf0);
   endtask : t_wrap

   task automatic t_errors();
      int c;
      good[0] = 4'h1;
      acc(1'b0, 2'h0, MA, 8'hb9, 1'b1, 8'h03);
      acc(1'b0, 2'h0, MA, 8'hd4, 1'b1, 8'h00);
      err[0] = 3'h7;
      acc(1'b0, 2'h0, MA, 8'hd2, 1'b1, 8'h01);
      for (c = 0; c < DW && eq[0] === 4'h0; c++) step(1);
      chk(c < DW, "errors did not shorten dwell");
      step(3 * DW);
      chk(eq_lk[0] === 1'b0, "locked despite errors");
      err[0] = 3'h0;
      wait_lock(0, 1'b1, 17 * DW, c);
      chk(eq[0] === 4'h1, "lock once errors stop");
   endtask : t_errors

   task automatic t_first();
      bit hit;
      bit again;
      good[0] = 4'h2;
      {hit, again} = 2'b00;
      acc(1'b0, 2'h0, MA, 8'hd2, 1'b1, 8'h02);
      acc(1'b0, 2'h0, MA, 8'h0c, 1'b1, 8'h0e);
      acc(1'b0, 2'h0, MA, 8'h0c, 1'b1, 8'h0f);
      for (int i = 0; i < 8 * DW && eq_lk[0] !== 1'b1; i++) begin
         step(1);
         hit |= (eq[0] === 4'h2);
         again |= hit && (eq[0] === 4'h0);
      end
      chk(again && eq_lk[0] === 1'b1 && eq[0] === 4'h2, "no restart after first lock");
   endtask : t_first

   task automatic t_freeze();
      int c;
      ce = 1'b0;
      good[0] = 4'h4;
      step(2 * DW);
      chk(eq[0] === 4'h2 && eq_lk[0] === 1'b1, "state moved with enable low");
      ce = 1'b1;
      wait_lock(0, 1'b0, 4, c);
      chk(eq[0] === 4'h3, "no step after freeze");
      chk(eq[3] === 4'h7 && eq_lk[3] === 1'b1, "port 3 not held");
   endtask : t_freeze

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      {rst_n, req, err, good} = '0;
      good[3:1] = {3{4'h7}};
      ce = 1'b1;
      miscompares = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      t_reset();
      t_enable();
      t_paging();
      t_search();
      t_wrap();
      t_errors();
      t_first();
      t_freeze();
      test_done();
   end
endmodule : rxpeq_top_test

`default_nettype wire
